// >>> rtc_defs.vh
// Functional notes
// - answer as bus slave at A3h for reads and A2h for writes
// - serial bus runs up to 400 kbit/s; master keeps below that
// - register pointer advances by one after each data byte read or written
// - sixteen 8-bit registers sit behind the pointer
// - the two control and status registers are at 00h and 01h
// - seconds through years counters occupy 02h to 08h
// - alarm match registers occupy 09h to 0Ch
// - square-wave frequency is chosen by the register at 0Dh
// - time, date and alarm values are held in BCD
// - time counters freeze while a bus transfer is in progress
// - square wave selectable 32.768 kHz, 1.024 kHz, 32 Hz, 1 Hz; 32.768 default
// - square-wave pin is open-drain, on after reset, released when disabled
// - master writes zero to reserved bits; reads may return either value
// - don't-care bits never steer any logic
// - interrupt pin is open-drain, pulled low when active
// - divider from the 32.768 kHz oscillator feeds the time counters
// - writing control register two ANDs written bits into alarm and timer flags
// - interrupt active when alarm flag and enable, or timer flag and enable
// - halt bit holds divider at zero and stops time; 32.768 kHz output continues
// - alarm and timer flags stay set until cleared over the bus
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH
`define SLAVE_ADDR   7'h51
`define REG_CTRL1    4'h0
`define REG_CTRL2    4'h1
`define REG_SEC      4'h2
`define REG_MIN      4'h3
`define REG_HOUR     4'h4
`define REG_DAY      4'h5
`define REG_WDAY     4'h6
`define REG_MON      4'h7
`define REG_YEAR     4'h8
`define REG_AL_MIN   4'h9
`define REG_AL_HOUR  4'hA
`define REG_AL_DAY   4'hB
`define REG_AL_WDAY  4'hC
`define REG_SQW      4'hD
`define REG_TCTRL    4'hE
`define REG_TVAL     4'hF
`define BIT_STOP     5
`define BIT_AF       3
`define BIT_TF       2
`define BIT_AIE      1
`define BIT_TIE      0
`define BIT_EN       7
`define BIT_CENT     7
`define RST_CTRL1    8'h08
`define RST_SEC      8'h80
`define RST_ONE      8'h01
`define RST_SQW      8'h80
`define RST_ZERO     8'h00
`define DIV_MAX      15'h7FFF
`define DIV_4096     3'h7
`define DIV_64       9'h1FF
`define TAP_1024     4
`define TAP_32       9
`define TAP_1        14
`endif

// >>> rtc_i2c_regs.v
`timescale 1ns/10ps
`include "rtc_defs.vh"
module i2c_rtc_calendar_regs (
   // clock and reset
   input  wire       i_sys_clk,
   input  wire       i_rst,
   // oscillator
   input  wire       i_crystal_in,
   output reg        o_crystal_out,
   // serial bus
   input  wire       i_scl,
   input  wire       i_sda,
   output wire       o_sda,
   output wire       o_sda_oe_n,
   // interrupt, open drain
   output wire       o_int,
   output reg        o_int_oe_n,
   // square wave, open drain
   output wire       o_square_wave_out,
   output reg        o_square_wave_out_oe_n
);

   localparam [6:0] S_IDLE  = 7'h01;
   localparam [6:0] S_ADDR  = 7'h02;
   localparam [6:0] S_AACK  = 7'h04;
   localparam [6:0] S_WDATA = 7'h08;
   localparam [6:0] S_WACK  = 7'h10;
   localparam [6:0] S_RDATA = 7'h20;
   localparam [6:0] S_RACK  = 7'h40;

   reg  [7:0]  rf [0:15];
   reg         scl_s1, scl_s2, scl_d;
   reg         sda_s1, sda_s2, sda_d;
   reg         xt_s1, xt_s2, xt_d;
   reg  [14:0] div;
   reg  [5:0]  tmin;
   reg  [6:0]  st;
   reg  [3:0]  bitc;
   reg  [7:0]  shreg;
   reg  [7:0]  tx;
   reg  [3:0]  ptr;
   reg         rw;
   reg         first;
   reg         nack;
   reg         sda_low;
   reg         wr_stb;
   reg  [3:0]  wr_addr;
   reg  [7:0]  wr_data;
   reg         pend;
   reg         alarm_chk;
   integer     k;

   // reset contents of the register file
   function [7:0] rst_val;
      input [3:0] a;
      begin
         case (a)
            `REG_CTRL1: rst_val = `RST_CTRL1;
            `REG_SEC:   rst_val = `RST_SEC;
            `REG_DAY:   rst_val = `RST_ONE;
            `REG_MON:   rst_val = `RST_ONE;
            `REG_SQW:   rst_val = `RST_SQW;
            default:    rst_val = `RST_ZERO;
         endcase
      end
   endfunction

   // bcd increment of one digit pair
   function [7:0] bcd_inc;
      input [7:0] v;
      begin
         if (v[3:0] == 4'h9)
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
         else
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   // last day of a month, leap years every fourth year
   function [7:0] last_day;
      input [7:0] mon;
      input [7:0] yr;
      reg   [1:0] m4;
      begin
         m4 = yr[1:0] + {yr[4], 1'b0};
         case (mon)
            8'h02:   last_day = (m4 == 2'h0) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            default: last_day = 8'h31;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; first stage feeds only the second
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d  <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d  <= 1'b1;
         xt_s1  <= 1'b0;
         xt_s2  <= 1'b0;
         xt_d   <= 1'b0;
      end else begin
         scl_s1 <= i_scl;
         scl_s2 <= scl_s1;
         scl_d  <= scl_s2;
         sda_s1 <= i_sda;
         sda_s2 <= sda_s1;
         sda_d  <= sda_s2;
         xt_s1  <= i_crystal_in;
         xt_s2  <= xt_s1;
         xt_d   <= xt_s2;
      end
   end

   wire scl_rise = scl_s2 & ~scl_d;
   wire scl_fall = ~scl_s2 & scl_d;
   wire start    = scl_s2 & scl_d & sda_d & ~sda_s2;
   wire stop     = scl_s2 & scl_d & ~sda_d & sda_s2;
   wire xt_rise  = xt_s2 & ~xt_d;

   ////////////////////////////////////////////////////////////////////////
   // oscillator divider and tick sources
   wire halt     = rf[`REG_CTRL1][`BIT_STOP];
   wire sec_tick = xt_rise & ~halt & (div == `DIV_MAX);
   wire t4096    = xt_rise & ~halt & (div[2:0] == `DIV_4096);
   wire t64      = xt_rise & ~halt & (div[8:0] == `DIV_64);
   wire t60      = sec_tick & (tmin == 6'h3B);
   reg  tmr_tick;

   // timer source select
   always @* begin
      case (rf[`REG_TCTRL][1:0])
         2'h0:    tmr_tick = t4096;
         2'h1:    tmr_tick = t64;
         2'h2:    tmr_tick = sec_tick;
         default: tmr_tick = t60;
      endcase
   end

   // divider held at zero while halted, so output taps stop too
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         div  <= 15'h0000;
         tmin <= 6'h00;
      end else if (halt) begin
         div  <= 15'h0000;
         tmin <= 6'h00;
      end else if (xt_rise) begin
         div  <= div + 15'h0001;
         if (sec_tick)
            tmin <= (tmin == 6'h3B) ? 6'h00 : tmin + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial bus slave; sda only changes while scl is low, except a release on a start or stop
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         st      <= S_IDLE;
         bitc    <= 4'h0;
         shreg   <= 8'h00;
         tx      <= 8'h00;
         ptr     <= 4'h0;
         rw      <= 1'b0;
         first   <= 1'b0;
         nack    <= 1'b0;
         sda_low <= 1'b0;
         wr_stb  <= 1'b0;
         wr_addr <= 4'h0;
         wr_data <= 8'h00;
      end else begin
         wr_stb <= 1'b0;
         if (start) begin
            st      <= S_ADDR;
            bitc    <= 4'h0;
            sda_low <= 1'b0;
         end else if (stop) begin
            st      <= S_IDLE;
            sda_low <= 1'b0;
         end else if (scl_rise) begin
            case (st)
               S_ADDR, S_WDATA: begin
                  shreg <= {shreg[6:0], sda_s2};
                  bitc  <= bitc + 4'h1;
               end
               S_RDATA: bitc <= bitc + 4'h1;
               S_RACK:  nack <= sda_s2;
               default: ;
            endcase
         end else if (scl_fall) begin
            case (st)
               S_ADDR: begin
                  if (bitc == 4'h8) begin
                     if (shreg[7:1] == `SLAVE_ADDR) begin
                        sda_low <= 1'b1;
                        rw      <= shreg[0];
                        st      <= S_AACK;
                     end else begin
                        st <= S_IDLE;
                     end
                  end
               end
               S_AACK, S_RACK: begin
                  bitc <= 4'h0;
                  if (st == S_RACK && nack) begin
                     sda_low <= 1'b0;
                     st      <= S_IDLE;
                  end else if (st == S_RACK || rw) begin
                     tx      <= rf[ptr];
                     sda_low <= ~rf[ptr][7];
                     ptr     <= ptr + 4'h1;
                     st      <= S_RDATA;
                  end else begin
                     sda_low <= 1'b0;
                     first   <= 1'b1;
                     st      <= S_WDATA;
                  end
               end
               S_WDATA: begin
                  if (bitc == 4'h8) begin
                     sda_low <= 1'b1;
                     first   <= 1'b0;
                     st      <= S_WACK;
                     if (first) begin
                        ptr <= shreg[3:0];
                     end else begin
                        wr_stb  <= 1'b1;
                        wr_addr <= ptr;
                        wr_data <= shreg;
                        ptr     <= ptr + 4'h1;
                     end
                  end
               end
               S_WACK: begin
                  sda_low <= 1'b0;
                  bitc    <= 4'h0;
                  st      <= S_WDATA;
               end
               S_RDATA: begin
                  if (bitc == 4'h8) begin
                     sda_low <= 1'b0;
                     st      <= S_RACK;
                  end else begin
                     sda_low <= ~tx[3'h7 - bitc[2:0]];
                  end
               end
               default: st <= S_IDLE;
            endcase
         end
      end
   end

   assign o_sda      = 1'b0;
   assign o_sda_oe_n = ~sda_low;

   ////////////////////////////////////////////////////////////////////////
   // time advance waits while the bus holds the device addressed
   wire busy    = ~(st == S_IDLE || st == S_ADDR);
   wire advance = pend & ~busy & ~wr_stb;

   // alarm compare once per new minute; bit 7 set disables a field
   wire m_ok  = rf[`REG_AL_MIN][7]  | (rf[`REG_AL_MIN][6:0] == rf[`REG_MIN][6:0]);
   wire h_ok  = rf[`REG_AL_HOUR][7] | (rf[`REG_AL_HOUR][5:0] == rf[`REG_HOUR][5:0]);
   wire d_ok  = rf[`REG_AL_DAY][7]  | (rf[`REG_AL_DAY][5:0] == rf[`REG_DAY][5:0]);
   wire w_ok  = rf[`REG_AL_WDAY][7] | (rf[`REG_AL_WDAY][2:0] == rf[`REG_WDAY][2:0]);
   wire any_en = ~(rf[`REG_AL_MIN][7] & rf[`REG_AL_HOUR][7] &
                   rf[`REG_AL_DAY][7] & rf[`REG_AL_WDAY][7]);
   wire alarm_hit = alarm_chk & m_ok & h_ok & d_ok & w_ok & any_en;
   wire t_en      = rf[`REG_TCTRL][`BIT_EN];
   wire timer_hit = tmr_tick & t_en & (rf[`REG_TVAL] == 8'h01);
   wire ctl2_wr   = wr_stb & (wr_addr == `REG_CTRL2);

   // masked fields; don't-care bits never reach the counters
   wire [7:0] sec  = {1'b0, rf[`REG_SEC][6:0]};
   wire [7:0] mnt  = {1'b0, rf[`REG_MIN][6:0]};
   wire [7:0] hr   = {2'b00, rf[`REG_HOUR][5:0]};
   wire [7:0] dy   = {2'b00, rf[`REG_DAY][5:0]};
   wire [2:0] wd   = rf[`REG_WDAY][2:0];
   wire [7:0] mon  = {3'b000, rf[`REG_MON][4:0]};
   wire [7:0] yr   = rf[`REG_YEAR];
   // incremented copies; a function result cannot be part-selected
   wire [7:0] sec_up = bcd_inc(sec);
   wire [7:0] mon_up = bcd_inc(mon);

   ////////////////////////////////////////////////////////////////////////
   // register file: bus writes, bcd time chain, flags, timer
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         for (k = 0; k < 16; k = k + 1)
            rf[k] <= rst_val(k[3:0]);
         pend      <= 1'b0;
         alarm_chk <= 1'b0;
      end else begin
         alarm_chk <= 1'b0;
         // a tick arriving while one is applied is kept
         pend <= (pend & ~advance) | sec_tick;
         if (wr_stb) begin
            if (ctl2_wr) begin
               rf[`REG_CTRL2] <= {wr_data[7:4],
                  (rf[`REG_CTRL2][`BIT_AF] & wr_data[`BIT_AF]) | alarm_hit,
                  (rf[`REG_CTRL2][`BIT_TF] & wr_data[`BIT_TF]) | timer_hit,
                  wr_data[1:0]};
            end else begin
               rf[wr_addr] <= wr_data;
            end
         end else if (advance) begin
            // seconds through years, carrying upward
            if (sec == 8'h59) begin
               rf[`REG_SEC] <= {rf[`REG_SEC][7], 7'h00};
               alarm_chk    <= 1'b1;
               if (mnt == 8'h59) begin
                  rf[`REG_MIN] <= 8'h00;
                  if (hr == 8'h23) begin
                     rf[`REG_HOUR] <= 8'h00;
                     rf[`REG_WDAY] <= (wd == 3'h6) ? 8'h00 : {5'h00, wd + 3'h1};
                     if (dy >= last_day(mon, yr)) begin
                        rf[`REG_DAY] <= 8'h01;
                        if (mon == 8'h12) begin
                           rf[`REG_MON] <= {~rf[`REG_MON][`BIT_CENT], 7'h01};
                           rf[`REG_YEAR] <= (yr == 8'h99) ? 8'h00 : bcd_inc(yr);
                        end else begin
                           rf[`REG_MON] <= {rf[`REG_MON][`BIT_CENT], 2'b00,
                                            mon_up[4:0]};
                        end
                     end else begin
                        rf[`REG_DAY] <= bcd_inc(dy);
                     end
                  end else begin
                     rf[`REG_HOUR] <= bcd_inc(hr);
                  end
               end else begin
                  rf[`REG_MIN] <= bcd_inc(mnt);
               end
            end else begin
               rf[`REG_SEC] <= {rf[`REG_SEC][7], sec_up[6:0]};
            end
         end
         // hardware sets flags; set wins over a clearing write
         if (!ctl2_wr && alarm_hit)
            rf[`REG_CTRL2][`BIT_AF] <= 1'b1;
         if (!ctl2_wr && timer_hit)
            rf[`REG_CTRL2][`BIT_TF] <= 1'b1;
         // countdown stops at zero; a bus write takes the value instead
         if (tmr_tick && t_en && rf[`REG_TVAL] != 8'h00 &&
             !(wr_stb && wr_addr == `REG_TVAL))
            rf[`REG_TVAL] <= rf[`REG_TVAL] - 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // open-drain outputs; enable is low while pulling the pin low
   wire irq = (rf[`REG_CTRL2][`BIT_AF] & rf[`REG_CTRL2][`BIT_AIE]) |
              (rf[`REG_CTRL2][`BIT_TF] & rf[`REG_CTRL2][`BIT_TIE]);
   reg  wave;

   // frequency select; 32.768 kHz tap bypasses the divider
   always @* begin
      case (rf[`REG_SQW][1:0])
         2'h0:    wave = xt_s2;
         2'h1:    wave = div[`TAP_1024];
         2'h2:    wave = div[`TAP_32];
         default: wave = div[`TAP_1];
      endcase
   end

   // registered pin drives and oscillator feedback
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_int_oe_n             <= 1'b1;
         o_square_wave_out_oe_n <= 1'b1;
         o_crystal_out          <= 1'b1;
      end else begin
         o_int_oe_n             <= ~irq;
         o_square_wave_out_oe_n <= ~(rf[`REG_SQW][`BIT_EN] & ~wave);
         o_crystal_out          <= ~xt_s2;
      end
   end

   assign o_int             = 1'b0;
   assign o_square_wave_out = 1'b0;

endmodule // i2c_rtc_calendar_regs

// >>> rtc_regs_props.sv
`timescale 1ns/10ps
module rtc_regs_props (
   // clock and reset
   input wire i_sys_clk,
   input wire i_rst,
   // oscillator
   input wire i_crystal_in,
   input wire o_crystal_out,
   // serial bus
   input wire i_scl,
   input wire i_sda,
   input wire o_sda,
   input wire o_sda_oe_n,
   // open-drain outputs
   input wire o_int,
   input wire o_int_oe_n,
   input wire o_square_wave_out,
   input wire o_square_wave_out_oe_n
);
   logic [3:0] rcnt;
   ////////////////////////////////////////////////////////////////////////
   // cycles since reset, saturating; synchronisers still hold stale levels early on
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rcnt <= 4'h0;
      end else if (rcnt != 4'hF) begin
         rcnt <= rcnt + 4'h1;
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////////////////
   // open-drain pins may only ever pull low
   a_sda_only_low: assert property (o_sda == 1'h0)
      else $error("data pin drives high");
   a_int_only_low: assert property (o_int == 1'h0)
      else $error("interrupt pin drives high");
   a_sqw_only_low: assert property (o_square_wave_out == 1'h0)
      else $error("square wave pin drives high");
   // reset must leave every pin released, checked without the reset disable
   a_reset_releases_pins: assert property (disable iff (1'h0)
      i_rst && $past(i_rst) |-> o_sda_oe_n && o_int_oe_n && o_square_wave_out_oe_n && o_crystal_out)
      else $error("pins not released in reset");
   // the slave starts pulling data only while the bus clock is low
   a_pull_scl_low: assert property ($fell(o_sda_oe_n) |-> !i_scl)
      else $error("data pulled while clock high");
   // with the clock high the drive moves only after a start or stop on the wire
   a_sda_steady_high: assert property ($changed(o_sda_oe_n) && i_scl |->
      $past(i_sda, 3) != $past(i_sda, 8))
      else $error("data drive moved while clock high");
   a_xtal_inverse: assert property (rcnt > 4'h5 |-> o_crystal_out == !$past(i_crystal_in, 3))
      else $error("oscillator output not inverse of input");
   // square wave steps only on oscillator edges or on a register write (clock low)
   a_sqw_follows_xtal: assert property (rcnt == 4'hF && $changed(o_square_wave_out_oe_n) |->
      $past(i_crystal_in, 2) != $past(i_crystal_in, 8) || !i_scl)
      else $error("square wave moved without oscillator edge");
   c_ack_pull: cover property ($fell(o_sda_oe_n));
   c_int_low: cover property ($fell(o_int_oe_n));
   c_sqw_toggle: cover property ($changed(o_square_wave_out_oe_n));
endmodule // rtc_regs_props

bind i2c_rtc_calendar_regs rtc_regs_props chk (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_crystal_in(i_crystal_in), .o_crystal_out(o_crystal_out),
   .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_int(o_int),
   .o_int_oe_n(o_int_oe_n), .o_square_wave_out(o_square_wave_out),
   .o_square_wave_out_oe_n(o_square_wave_out_oe_n)
);

// >>> i2c_master_model.sv
`timescale 1ns/10ps
module i2c_master_model #(
   parameter int HALF = 17
) (
   // clock and wire level
   input  wire logic i_sys_clk,
   input  wire logic i_sda,
   // pull-low controls
   output logic      o_scl_low,
   output logic      o_sda_low
);
   initial begin
      o_scl_low = 1'h0;
      o_sda_low = 1'h0;
   end
   ////////////////////////////////////////////////////////////////////////
   // one bus phase; three phases a bit keep the rate below 400 kbit/s
   task automatic tick();
      repeat (HALF) @(posedge i_sys_clk);
      #2;
   endtask
   // start, or repeated start when the clock is low
   task automatic start();
      o_sda_low = 1'h0;
      tick();
      o_scl_low = 1'h0;
      tick();
      o_sda_low = 1'h1;
      tick();
      o_scl_low = 1'h1;
      tick();
   endtask
   task automatic stop();
      o_sda_low = 1'h1;
      tick();
      o_scl_low = 1'h0;
      tick();
      o_sda_low = 1'h0;
      tick();
   endtask
   // data moves only while the clock is low; sampled late in the high phase
   task automatic bitx(input logic b, output logic r);
      o_sda_low = !b;
      tick();
      o_scl_low = 1'h0;
      tick();
      r = i_sda;
      o_scl_low = 1'h1;
      tick();
   endtask
   task automatic send(input logic [7:0] b, output logic nack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(b[i], r);
      bitx(1'h1, nack);
   endtask
   // last byte of a read is refused so the slave lets go
   task automatic recv(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'h1, b[i]);
      bitx(last, r);
   endtask
endmodule // i2c_master_model

// >>> tb.sv
`timescale 1ns/10ps
module tb;
   logic   i_sys_clk = 1'h0;
   logic   i_rst     = 1'h0;
   logic   xtal      = 1'h0;
   logic   m_scl_low, m_sda_low, n;
   logic   sda_oe_n, int_oe_n, sqw_oe_n;
   logic   scl_w, sda_w;
   integer failures  = 0;
   integer compares  = 0;
   int     k;
   ////////////////////////////////////////////////////////////////////////
   // clocks; the oscillator is sped up so square-wave periods stay short
   always #25 i_sys_clk = ~i_sys_clk;
   always #400 xtal = ~xtal;
   // wires are pulled up unless someone pulls low
   assign scl_w = !m_scl_low;
   assign sda_w = !(m_sda_low || !sda_oe_n);
   i2c_rtc_calendar_regs uut (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_crystal_in(xtal), .o_crystal_out(),
      .i_scl(scl_w), .i_sda(sda_w), .o_sda(), .o_sda_oe_n(sda_oe_n), .o_int(),
      .o_int_oe_n(int_oe_n), .o_square_wave_out(), .o_square_wave_out_oe_n(sqw_oe_n)
   );
   i2c_master_model host (
      .i_sys_clk(i_sys_clk), .i_sda(sda_w), .o_scl_low(m_scl_low), .o_sda_low(m_sda_low)
   );
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic ok(input logic c);
      check({7'h0, c}, 8'h01);
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge i_sys_clk);
      #2;
   endtask
   // write burst: pointer byte, then data bytes, each acknowledged
   task automatic wr(input logic [3:0] p, input logic [7:0] d[$]);
      host.start();
      host.send(8'hA2, n);
      check({7'h0, n}, 8'h00);
      host.send({4'h0, p}, n);
      check({7'h0, n}, 8'h00);
      foreach (d[i]) begin
         host.send(d[i], n);
         check({7'h0, n}, 8'h00);
      end
      host.stop();
   endtask
   // read burst after setting the pointer, through a repeated start
   task automatic rd(input logic [3:0] p, input logic [7:0] e[$]);
      logic [7:0] v;
      host.start();
      host.send(8'hA2, n);
      host.send({4'h0, p}, n);
      host.start();
      host.send(8'hA3, n);
      check({7'h0, n}, 8'h00);
      foreach (e[i]) begin
         host.recv(i == e.size() - 1, v);
         check(v, e[i]);
      end
      host.stop();
   endtask
   // counts square-wave steps; sampled before the edge's own updates land
   task automatic edges(input int c, output int t);
      logic last;
      t = 0;
      last = sqw_oe_n;
      repeat (c) begin
         @(posedge i_sys_clk);
         if (sqw_oe_n !== last) t++;
         last = sqw_oe_n;
      end
   endtask
   task automatic summarize();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // hang guard, well above the roughly 53000 cycles the tests need
   initial begin
      repeat (80000) @(posedge i_sys_clk);
      failures++;
      summarize();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      // raised by an event so the asynchronous reset branch runs at once
      #2;
      i_rst = 1'h1;
      repeat (6) @(posedge i_sys_clk);
      #2;
      i_rst = 1'h0;
      cyc(4);
      rd(4'h0, {8'h08, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01,
                8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h08});
      $display("test reset image done");
      wr(4'h9, {8'h59, 8'h23, 8'h31, 8'h06, 8'h81});
      wr(4'hF, {8'hAA, 8'h08});
      rd(4'h9, {8'h59, 8'h23, 8'h31, 8'h06, 8'h81, 8'h00, 8'hAA, 8'h08});
      $display("test burst and wrap done");
      edges(1024, k);
      ok(k >= 3 && k <= 5);
      wr(4'hD, {8'h00});
      edges(200, k);
      ok(k == 0 && sqw_oe_n === 1'h1);
      wr(4'hD, {8'h80});
      wr(4'h0, {8'h28});
      edges(320, k);
      ok(k >= 38 && k <= 41);
      wr(4'hE, {8'h80, 8'h02});
      cyc(600);
      rd(4'h1, {8'h00});
      wr(4'h0, {8'h08});
      cyc(600);
      rd(4'h1, {8'h04});
      wr(4'hD, {8'h82});
      edges(9000, k);
      ok(k >= 1 && k <= 2);
      $display("test square wave and halt done");
      ok(int_oe_n === 1'h1);
      wr(4'h1, {8'h05});
      cyc(4);
      ok(int_oe_n === 1'h0);
      wr(4'h1, {8'h03});
      cyc(4);
      ok(int_oe_n === 1'h1);
      rd(4'h1, {8'h03});
      $display("test interrupt done");
      host.start();
      host.send(8'hA4, n);
      check({7'h0, n}, 8'h01);
      host.stop();
      rd(4'h1, {8'h03});
      $display("test foreign address done");
      summarize();
   end
endmodule // tb
